// *** design/fsb_data_receiver.sv ***
// Receiving agent: samples the strobed lanes, undoes inversion, hands words on
// Functional notes
// - Sixty-four shared active-low data lines
// - Data valid only while valid strobe asserted
// - Four data values per bus clock
// - Capture on falling edge of lane strobes
// - Four sixteen-bit lanes with own strobes, flags
// - Active flag means lane sampled active high
// - Flag travels with data, marks inverted lane
// - Invert allowed when over half bits low
`timescale 1ns/1ps
module fsb_data_receiver (
  input wire logic sample_clk,
  input wire logic clock,
  input wire logic srst,
  fsb_data_if.rcv bus,
  output logic out_valid,
  output logic [fsb_dbi_pkg::DATA_W-1:0] out_data,
  input wire logic out_ready,
  output logic overrun,
  output logic order_error
);

  localparam int PIN_W = fsb_dbi_pkg::DATA_W + 3 * fsb_dbi_pkg::LANES + 1;

  // ------------------------------------------------------------
  // Reset into the sampling domain
  // ------------------------------------------------------------
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge sample_clk) begin
    rst_s1_q <= srst;
    rst_s2_q <= rst_s1_q;
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Strobes and data share the same two-stage delay, keeping them aligned
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic [fsb_dbi_pkg::LANES-1:0] pos_s3_q, neg_s3_q;
  fsb_dbi_pkg::word_t d_s;
  logic [fsb_dbi_pkg::LANES-1:0] flag_s, pos_s, neg_s;
  logic valid_s;
  assign pins = {bus.data_n, bus.lane_invert_flag_n, bus.lane_strobe_pos_n, bus.lane_strobe_neg_n,
                 bus.data_valid_strobe_n};
  assign {d_s, flag_s, pos_s, neg_s, valid_s} = pin_s2_q;

  always_ff @(posedge sample_clk) begin
    pin_s1_q <= pins;
    pin_s2_q <= pin_s1_q;
    pos_s3_q <= pos_s;
    neg_s3_q <= neg_s;
  end

  // ------------------------------------------------------------
  // Lane capture in the sampling domain
  // ------------------------------------------------------------
  fsb_dbi_pkg::word_t word_q, word_d;
  logic [fsb_dbi_pkg::LANES-1:0] got_q, got_d, exp_pos_q, exp_pos_d;
  logic [fsb_dbi_pkg::LANES-1:0] fall_pos, fall_neg;
  logic lane_valid_q, lane_valid_d;
  logic publish;
  logic order_q, order_d;

  assign fall_pos = pos_s3_q & ~pos_s;
  assign fall_neg = neg_s3_q & ~neg_s;

  // Each lane is decoded with its own strobe pair and its own flag
  always_comb begin
    logic [fsb_dbi_pkg::LANE_W-1:0] raw;
    raw = '0;
    word_d = word_q;
    got_d = got_q;
    exp_pos_d = exp_pos_q;
    lane_valid_d = lane_valid_q;
    order_d = order_q;
    for (int n = 0; n < fsb_dbi_pkg::LANES; n++) begin
      raw = d_s[n*fsb_dbi_pkg::LANE_W +: fsb_dbi_pkg::LANE_W];
      if (fall_pos[n] || fall_neg[n]) begin
        // Active flag: lane was driven inverted, so read it active high
        word_d[n*fsb_dbi_pkg::LANE_W +: fsb_dbi_pkg::LANE_W] = flag_s[n] ? ~raw : raw;
        got_d[n] = 1'b1;
        exp_pos_d[n] = fall_neg[n];
        // A fall on the wrong strobe of the pair breaks the sub-phase order
        if ((fall_pos[n] && !exp_pos_q[n]) || (fall_neg[n] && exp_pos_q[n]) || (fall_pos[n] && fall_neg[n])) begin
          order_d = 1'b1;
        end
      end
    end
    if (fall_pos[0] || fall_neg[0]) begin
      lane_valid_d = !valid_s;
    end
    publish = &got_d;
    if (publish) begin
      got_d = '0;
    end
  end

  always_ff @(posedge sample_clk) begin
    if (rst_s2_q) begin
      word_q <= '0;
      got_q <= '0;
      exp_pos_q <= '1;
      lane_valid_q <= 1'b0;
      order_q <= 1'b0;
    end else begin
      word_q <= word_d;
      got_q <= got_d;
      exp_pos_q <= exp_pos_d;
      lane_valid_q <= lane_valid_d;
      order_q <= order_d;
    end
  end

  // ------------------------------------------------------------
  // Word handshake toward the clock domain
  // ------------------------------------------------------------
  // The bus cannot be stalled, so a word arriving before the last is
  // acknowledged is dropped and flagged rather than corrupting the held one
  fsb_dbi_pkg::word_t xfer_q, xfer_d;
  logic req_q, req_d, pend_q, pend_d, ovr_q, ovr_d;
  logic ack_s1_q, ack_s2_q;
  logic ack_q;

  always_comb begin
    xfer_d = xfer_q;
    req_d = req_q;
    pend_d = pend_q && (ack_s2_q != req_q);
    ovr_d = ovr_q;
    // Sub-phases without a valid strobe carry nothing and are skipped
    if (publish && lane_valid_d) begin
      if (pend_d) begin
        ovr_d = 1'b1;
      end else begin
        xfer_d = word_d;
        req_d = !req_q;
        pend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sample_clk) begin
    ack_s1_q <= ack_q;
    ack_s2_q <= ack_s1_q;
    if (rst_s2_q) begin
      xfer_q <= '0;
      req_q <= 1'b0;
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      xfer_q <= xfer_d;
      req_q <= req_d;
      pend_q <= pend_d;
      ovr_q <= ovr_d;
    end
  end

  // ------------------------------------------------------------
  // Clock domain: handshake end and two-entry output buffer
  // ------------------------------------------------------------
  logic req_s1_q, req_s2_q;
  logic [1:0] err_s1_q, err_s2_q;
  logic ack_d;
  fsb_dbi_pkg::word_t head_q, head_d, skid_q, skid_d;
  logic head_v_q, head_v_d, skid_v_q, skid_v_d;
  logic push;

  // A full buffer holds the acknowledge back, pushing the stall to the link side
  always_comb begin
    push = (req_s2_q != ack_q) && !skid_v_q;
    ack_d = push ? req_s2_q : ack_q;
    head_d = head_q;
    skid_d = skid_q;
    head_v_d = head_v_q;
    skid_v_d = skid_v_q;
    if (head_v_q && out_ready) begin
      head_d = skid_q;
      head_v_d = skid_v_q;
      skid_v_d = 1'b0;
    end
    if (push) begin
      if (!head_v_d) begin
        head_d = xfer_q;
        head_v_d = 1'b1;
      end else begin
        skid_d = xfer_q;
        skid_v_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
    err_s1_q <= {ovr_q, order_q};
    err_s2_q <= err_s1_q;
    if (srst) begin
      ack_q <= 1'b0;
      head_q <= '0;
      skid_q <= '0;
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      overrun <= 1'b0;
      order_error <= 1'b0;
    end else begin
      ack_q <= ack_d;
      head_q <= head_d;
      skid_q <= skid_d;
      head_v_q <= head_v_d;
      skid_v_q <= skid_v_d;
      overrun <= err_s2_q[1];
      order_error <= err_s2_q[0];
    end
  end

  assign out_valid = head_v_q;
  assign out_data = head_q;

endmodule

// *** inc/fsb_dbi_pkg.sv ***
// Shared constants and helpers for the quad-pumped inverted data link
package fsb_dbi_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int LANES = 4;
  localparam int LANE_W = 16;
  localparam int SUBPHASES = 4;
  localparam int CNT_W = 8;
  localparam int SUB_W = 2;
  // Lane inverts only when strictly more than half its bits would be low
  localparam int INV_THRESH = LANE_W / 2;

  // ------------------------------------------------------------
  // Timing and idle levels
  // ------------------------------------------------------------
  // Clock cycles per sub-phase; four sub-phases form one bus clock period
  localparam int PHASE_CYC = 8;
  localparam int BUS_CLK_HIGH_SUBS = 2;
  localparam logic [DATA_W-1:0] DATA_IDLE = 64'hffffffffffffffff;
  localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
  localparam logic LINE_IDLE = 1'h1;

  typedef logic [DATA_W-1:0] word_t;

  // Number of set bits in one lane, which become electrically low bits
  function automatic logic [4:0] lane_ones(input logic [LANE_W-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < LANE_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

endpackage

// *** inc/fsb_data_if.sv ***
// Shared data-phase wires between a driving agent and a receiving agent
`timescale 1ns/1ps
interface fsb_data_if;

  // ------------------------------------------------------------
  // Driver side of each pin: output value and output enable; the bus clock has a value only
  // ------------------------------------------------------------
  logic [fsb_dbi_pkg::DATA_W-1:0] data_n_o;
  logic data_oe;
  logic [fsb_dbi_pkg::LANES-1:0] invert_flag_n_o;
  logic invert_oe;
  logic valid_n_o;
  logic valid_oe;
  logic [fsb_dbi_pkg::LANES-1:0] strobe_pos_n_o;
  logic [fsb_dbi_pkg::LANES-1:0] strobe_neg_n_o;
  logic strobe_oe;
  logic bus_clk;

  // ------------------------------------------------------------
  // Resolved lines; undriven lines float high through pull-ups
  // ------------------------------------------------------------
  logic [fsb_dbi_pkg::DATA_W-1:0] data_n;
  logic [fsb_dbi_pkg::LANES-1:0] lane_invert_flag_n;
  logic data_valid_strobe_n;
  logic [fsb_dbi_pkg::LANES-1:0] lane_strobe_pos_n;
  logic [fsb_dbi_pkg::LANES-1:0] lane_strobe_neg_n;

  assign data_n = data_oe ? data_n_o : fsb_dbi_pkg::DATA_IDLE;
  assign lane_invert_flag_n = invert_oe ? invert_flag_n_o : fsb_dbi_pkg::LANES_IDLE;
  assign data_valid_strobe_n = valid_oe ? valid_n_o : fsb_dbi_pkg::LINE_IDLE;
  assign lane_strobe_pos_n = strobe_oe ? strobe_pos_n_o : fsb_dbi_pkg::LANES_IDLE;
  assign lane_strobe_neg_n = strobe_oe ? strobe_neg_n_o : fsb_dbi_pkg::LANES_IDLE;

  modport drv (
    output data_n_o, data_oe, invert_flag_n_o, invert_oe, valid_n_o, valid_oe,
    output strobe_pos_n_o, strobe_neg_n_o, strobe_oe, bus_clk
  );
  modport rcv (
    input data_n, lane_invert_flag_n, data_valid_strobe_n, lane_strobe_pos_n, lane_strobe_neg_n
  );

endinterface

// *** design/fsb_data_driver.sv ***
// Driving agent: sends 64-bit words quad-pumped with per-lane inversion
`timescale 1ns/1ps
module fsb_data_driver #(
  parameter int PHASE_CYC = fsb_dbi_pkg::PHASE_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [fsb_dbi_pkg::DATA_W-1:0] in_data,
  output logic in_ready,
  input wire logic invert_enable,
  fsb_data_if.drv bus
);

  localparam logic [fsb_dbi_pkg::CNT_W-1:0] LAST = fsb_dbi_pkg::CNT_W'(PHASE_CYC - 1);
  localparam logic [fsb_dbi_pkg::CNT_W-1:0] MID = fsb_dbi_pkg::CNT_W'(PHASE_CYC / 2);
  localparam logic [fsb_dbi_pkg::SUB_W-1:0] CLK_SUBS = fsb_dbi_pkg::SUB_W'(fsb_dbi_pkg::BUS_CLK_HIGH_SUBS);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [fsb_dbi_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [fsb_dbi_pkg::SUB_W-1:0] sub_q, sub_d;
  fsb_dbi_pkg::word_t hold_q, hold_d;
  logic hold_full_q, hold_full_d;
  logic ready_q, ready_d;
  fsb_dbi_pkg::word_t data_n_q, data_n_d;
  logic [fsb_dbi_pkg::LANES-1:0] flag_n_q, flag_n_d;
  logic valid_n_q, valid_n_d;
  logic [fsb_dbi_pkg::LANES-1:0] pos_n_q, pos_n_d, neg_n_q, neg_n_d;
  logic bus_clk_q, bus_clk_d;
  logic oe_q;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // A word is launched at the start of a sub-phase and its strobe falls mid-phase
  always_comb begin
    logic [fsb_dbi_pkg::LANE_W-1:0] lane;
    logic inv;
    lane = '0;
    inv = 1'b0;
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    sub_d = (cnt_q == LAST) ? sub_q + 1'b1 : sub_q;
    hold_d = hold_q;
    hold_full_d = hold_full_q;
    data_n_d = data_n_q;
    flag_n_d = flag_n_q;
    valid_n_d = valid_n_q;
    pos_n_d = pos_n_q;
    neg_n_d = neg_n_q;
    if (cnt_q == '0) begin
      valid_n_d = !hold_full_q;
      data_n_d = fsb_dbi_pkg::DATA_IDLE;
      flag_n_d = fsb_dbi_pkg::LANES_IDLE;
      if (hold_full_q) begin
        hold_full_d = 1'b0;
        for (int n = 0; n < fsb_dbi_pkg::LANES; n++) begin
          lane = hold_q[n*fsb_dbi_pkg::LANE_W +: fsb_dbi_pkg::LANE_W];
          // Inversion is optional, so software may switch it off entirely
          inv = invert_enable && (fsb_dbi_pkg::lane_ones(lane) > 5'(fsb_dbi_pkg::INV_THRESH));
          data_n_d[n*fsb_dbi_pkg::LANE_W +: fsb_dbi_pkg::LANE_W] = inv ? lane : ~lane;
          flag_n_d[n] = !inv;
        end
      end
    end
    // Even sub-phases fall on the positive strobe, odd ones on the negative
    if (cnt_q == MID) begin
      pos_n_d = {fsb_dbi_pkg::LANES{sub_q[0]}};
      neg_n_d = {fsb_dbi_pkg::LANES{!sub_q[0]}};
    end
    if (in_valid && ready_q) begin
      hold_d = in_data;
      hold_full_d = 1'b1;
    end
    ready_d = !hold_full_d;
    bus_clk_d = sub_d < CLK_SUBS;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q <= '0;
      sub_q <= '0;
      hold_q <= '0;
      hold_full_q <= 1'b0;
      ready_q <= 1'b0;
      data_n_q <= fsb_dbi_pkg::DATA_IDLE;
      flag_n_q <= fsb_dbi_pkg::LANES_IDLE;
      valid_n_q <= fsb_dbi_pkg::LINE_IDLE;
      pos_n_q <= fsb_dbi_pkg::LANES_IDLE;
      neg_n_q <= fsb_dbi_pkg::LANES_IDLE;
      // Reset sits in sub-phase 0, where the bus clock is high, so the first period is not short
      bus_clk_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sub_q <= sub_d;
      hold_q <= hold_d;
      hold_full_q <= hold_full_d;
      ready_q <= ready_d;
      data_n_q <= data_n_d;
      flag_n_q <= flag_n_d;
      valid_n_q <= valid_n_d;
      pos_n_q <= pos_n_d;
      neg_n_q <= neg_n_d;
      bus_clk_q <= bus_clk_d;
      oe_q <= 1'b1;
    end
  end

  // Pins are released during reset so another agent may own the lines
  assign in_ready = ready_q;
  assign bus.data_n_o = data_n_q;
  assign bus.data_oe = oe_q;
  assign bus.invert_flag_n_o = flag_n_q;
  assign bus.invert_oe = oe_q;
  assign bus.valid_n_o = valid_n_q;
  assign bus.valid_oe = oe_q;
  assign bus.strobe_pos_n_o = pos_n_q;
  assign bus.strobe_neg_n_o = neg_n_q;
  assign bus.strobe_oe = oe_q;
  assign bus.bus_clk = bus_clk_q;

endmodule

// *** bench/fsb_data_properties.sv ***
// Concurrent checks on the shared data-phase wires
`timescale 1ns/1ps
module fsb_data_properties #(
  parameter int PHASE_CYC = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [63:0] data_n,
  input wire logic [3:0] lane_invert_flag_n,
  input wire logic data_valid_strobe_n,
  input wire logic [3:0] lane_strobe_pos_n,
  input wire logic [3:0] lane_strobe_neg_n,
  input wire logic bus_clk
);
  // --------
  // Timing of one sub-phase and one bus clock
  // --------
  localparam int HALF = PHASE_CYC / 2;
  localparam int BUS_CYC = 4 * PHASE_CYC;
  // Bus clock rises with the counter at zero, data moves one edge later, strobe half a phase after
  localparam int RISE_TO_FALL = HALF + 1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Lanes never disagree, so the receiver can wait for one common edge
  chk_lanes_together: assert property (lane_strobe_pos_n inside {4'h0, 4'hf} &&
    lane_strobe_neg_n inside {4'h0, 4'hf})
    else $error("lane strobes split");
  chk_pos_then_neg: assert property ($fell(lane_strobe_pos_n[0]) |-> ##PHASE_CYC $fell(lane_strobe_neg_n[0]))
    else $error("negative strobe late");
  chk_neg_then_pos: assert property ($fell(lane_strobe_neg_n[0]) |-> ##PHASE_CYC $fell(lane_strobe_pos_n[0]))
    else $error("positive strobe late");
  chk_strobe_pair_apart: assert property ($fell(lane_strobe_pos_n[0]) |-> lane_strobe_neg_n[0])
    else $error("both strobes low");
  // Four falls per bus clock, each half a sub-phase after the data moved
  chk_quad_pump: assert property ($rose(bus_clk) |-> ##RISE_TO_FALL $fell(lane_strobe_pos_n[0])
    ##PHASE_CYC $fell(lane_strobe_neg_n[0]) ##PHASE_CYC $fell(lane_strobe_pos_n[0])
    ##PHASE_CYC $fell(lane_strobe_neg_n[0]))
    else $error("not four transfers per bus clock");
  chk_bus_clk_period: assert property ($rose(bus_clk) |-> ##BUS_CYC $rose(bus_clk))
    else $error("bus clock period wrong");
  // Data, flags and valid must match three cycles before the capturing edge; data must also hold two cycles after
  chk_data_settled: assert property (($fell(lane_strobe_pos_n[0]) || $fell(lane_strobe_neg_n[0])) |->
    data_n == $past(data_n, 3) && lane_invert_flag_n == $past(lane_invert_flag_n, 3) &&
    data_valid_strobe_n == $past(data_valid_strobe_n, 3) ##1 $stable(data_n)[*2])
    else $error("data moved near strobe");
  chk_idle_lines_high: assert property (data_valid_strobe_n |->
    data_n == 64'hffffffffffffffff && lane_invert_flag_n == 4'hf)
    else $error("lines not idle without valid");
  // An inverted lane must have been heavy in ones before inversion
  for (genvar i = 0; i < 4; i++) begin : g_lane
    chk_flag_heavy_lane: assert property (!lane_invert_flag_n[i] |-> $countones(data_n[16*i +: 16]) > 8)
      else $error("light lane inverted");
  end

  cover property (!data_valid_strobe_n && lane_invert_flag_n == 4'h0);
  cover property (!data_valid_strobe_n && lane_invert_flag_n == 4'h5);
  cover property ($fell(data_valid_strobe_n) ##PHASE_CYC !data_valid_strobe_n);
endmodule

// *** bench/quad_pumped_data_bus_inversion_tb.sv ***
// Self-checking bench: driver and receiver joined by the shared data wires
`timescale 1ns/1ps
module quad_pumped_data_bus_inversion_tb;
  // --------
  // Stimulus, scoreboards and the link
  // --------
  logic clock = 1'h0;
  logic sample_clk = 1'h0;
  logic srst = 1'h1;
  logic in_valid = 1'h0;
  logic [63:0] in_data = 64'h0;
  logic in_ready;
  logic invert_enable = 1'h1;
  logic out_valid;
  logic [63:0] out_data;
  logic out_ready = 1'h1;
  logic overrun;
  logic order_error;
  int bad_count = 0;
  int checked = 0;
  logic [63:0] rx_q[$];
  logic [64:0] wire_q[$];
  logic [1:0] strobe_prev = 2'h3;
  logic [1:0] strobe_now;
  logic [67:0] wexp;
  // Lane counts 0/16, 8 vs 9 boundary, 1 vs 15 and mixed patterns
  logic [63:0] words [6] = '{64'h0, 64'hffffffffffffffff, 64'h00ff01ffff00ffff,
    64'h80007fff0001fffe, 64'h0123456789abcdef, 64'hfedcba9876543210};

  always #25 clock = ~clock;
  // Link sampling clock, phase unrelated to the system clock
  initial begin
    #3.7;
    forever #6 sample_clk = ~sample_clk;
  end

  fsb_data_if fsb_data_if_inst ();
  fsb_data_driver #(.PHASE_CYC(fsb_dbi_pkg::PHASE_CYC)) fsb_data_driver_inst (.clock(clock), .srst(srst),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .invert_enable(invert_enable),
    .bus(fsb_data_if_inst));
  fsb_data_receiver fsb_data_receiver_inst (.sample_clk(sample_clk), .clock(clock), .srst(srst), .bus(fsb_data_if_inst),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .overrun(overrun), .order_error(order_error));
  fsb_data_properties #(.PHASE_CYC(fsb_dbi_pkg::PHASE_CYC)) fsb_data_properties_inst (.clock(clock), .srst(srst),
    .data_n(fsb_data_if_inst.data_n), .lane_invert_flag_n(fsb_data_if_inst.lane_invert_flag_n),
    .data_valid_strobe_n(fsb_data_if_inst.data_valid_strobe_n), .lane_strobe_pos_n(fsb_data_if_inst.lane_strobe_pos_n),
    .lane_strobe_neg_n(fsb_data_if_inst.lane_strobe_neg_n), .bus_clk(fsb_data_if_inst.bus_clk));

  // --------
  // Shared tasks
  // --------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hold the word until in_ready is seen high at a falling edge, then through the next rising edge
  task automatic send(input logic [63:0] w);
    logic rdy;
    rdy = 1'h0;
    @(posedge clock);
    in_valid <= 1'h1;
    in_data <= w;
    for (int i = 0; i < 40 && !rdy; i++) begin
      @(negedge clock);
      rdy = in_ready;
      @(posedge clock);
    end
    in_valid <= 1'h0;
    chk({63'h0, rdy}, 64'h1);
    if (!rdy) tally_and_finish();
    rx_q.push_back(w);
    wire_q.push_back({invert_enable, w});
  endtask

  task automatic drain();
    for (int n = 0; n < 400 && rx_q.size() != 0; n++) @(posedge clock);
    chk({32'h0, rx_q.size()}, 64'h0);
    if (rx_q.size() != 0) tally_and_finish();
  endtask

  // Wire image per lane: inverted only when enabled and over half ones
  function automatic logic [67:0] encode(input logic [64:0] e);
    logic [15:0] v;
    logic inv;
    for (int i = 0; i < 4; i++) begin
      v = e[16*i +: 16];
      inv = e[64] && $countones(v) > 8;
      encode[16*i +: 16] = inv ? v : ~v;
      encode[64 + i] = ~inv;
    end
  endfunction

  // Watch the wires at each strobe fall of a valid sub-phase
  assign strobe_now = {fsb_data_if_inst.lane_strobe_pos_n[0], fsb_data_if_inst.lane_strobe_neg_n[0]};
  always @(posedge clock) begin
    strobe_prev <= strobe_now;
    if (!srst && (strobe_prev & ~strobe_now) != 2'h0 && fsb_data_if_inst.data_valid_strobe_n === 1'h0) begin
      chk({63'h0, wire_q.size() == 0}, 64'h0);
      if (wire_q.size() != 0) begin
        wexp = encode(wire_q.pop_front());
        chk(fsb_data_if_inst.data_n, wexp[63:0]);
        chk({60'h0, fsb_data_if_inst.lane_invert_flag_n}, {60'h0, wexp[67:64]});
      end
    end
  end

  // Receiver side scoreboard, a word per accepted handshake
  always @(posedge clock) begin
    if (!srst && out_valid === 1'h1 && out_ready) begin
      chk({63'h0, rx_q.size() == 0}, 64'h0);
      if (rx_q.size() != 0) chk(out_data, rx_q.pop_front());
    end
  end

  // --------
  // Main sequence
  // --------
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    repeat (3) @(posedge clock);
    // Back-to-back words with inversion allowed, then forbidden
    for (int i = 0; i < 6; i++) send(words[i]);
    drain();
    invert_enable <= 1'h0;
    for (int i = 0; i < 6; i++) send(words[i]);
    drain();
    // Stall the consumer: two fill the buffer, the third waits at the link
    invert_enable <= 1'h1;
    out_ready <= 1'h0;
    for (int i = 2; i < 5; i++) send(words[i]);
    repeat (40) @(posedge clock);
    chk({62'h0, out_valid, overrun}, 64'h2);
    chk(out_data, words[2]);
    out_ready <= 1'h1;
    drain();
    // Long idle stretch must deliver nothing and flag no fault
    repeat (100) @(posedge clock);
    chk({62'h0, overrun, order_error}, 64'h0);
    tally_and_finish();
  end
endmodule
